// >>> src/hedt_core.sv
// haptic event, diagnostic and resonance tracking logic
// assumes synchronous event strobes and a one-cycle register port
//
// Function
// - faults force and hold idle state
// - raised events pull alert pin low
// - fault byte plus warning, input detail registers
// - overcurrent, overheat, undervoltage faults, write-one clear
// - actuator fault on impedance, bemf, frequency problems
// - sequence fault summary with cause recorded
// - playback done flag, write-one clear
// - repeat started flag on requested repeat
// - warning flag held while warnings stand
// - sense saturation flag on converter saturation
// - three warning causes from supply, format
// - bad pattern id and memory corruption faults
// - pulse timeout clears after restart then write
// - flags write-one clear except the held warning flag, two masks
// - pi tracking with paired gain registers
// - proportional autoscale only after lock
// - actuator fault outside 50 to 300 Hz
// - tracking suspended below bemf floor
// - period now updated every half period
// - period average over last four halves
// - quick brake until no acceleration or threshold
// - one-shot resistance measure at first half
`timescale 1ns/1ps
`default_nettype none
module hedt_core (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        oc_evt,
   input  wire logic        hot_evt,
   input  wire logic        uv_evt,
   input  wire logic        act_imp_evt,
   input  wire logic        act_bemf_evt,
   input  wire logic        bad_id_evt,
   input  wire logic        mem_bad_evt,
   input  wire logic        pwm_tmo_evt,
   input  wire logic        pwm_restart,
   input  wire logic        done_evt,
   input  wire logic        seq_begin_evt,
   input  wire logic        sat_evt,
   input  wire logic        lim_evt,
   input  wire logic        boost_evt,
   input  wire logic        fmt_evt,
   input  wire logic        hp_tick,
   input  wire logic [13:0] hp_period,
   input  wire logic [7:0]  bemf_lvl,
   input  wire logic [7:0]  trk_err,
   input  wire logic        playing,
   input  wire logic        stop_req,
   input  wire logic        accel_zero,
   input  wire logic        first_drive,
   input  wire logic [9:0]  meas_res,
   input  wire logic [15:0] meas_scale,
   output logic             event_alert_pin_o,
   output logic             event_alert_pin_oe_b,
   output logic             hold_idle,
   output logic             brake_drive,
   output logic      [15:0] track_adj
);
   logic [4:0]  fault_q;
   logic [3:0]  note_q;
   logic [2:0]  warn_q, inf_q;
   logic [7:0]  mska_q, mskb_q, ctrl_q;
   logic [7:0]  lock_q, floor_q, brake_thr_q;
   logic [15:0] kp_q, ki_q, scale_q;
   logic [9:0]  res_q;
   logic [13:0] pnow_q, pavg_q;
   logic [13:0] hist_q [4];
   logic        pwm_rst_seen_q, locked_q, track_on;
   logic [23:0] integ_q, pterm;
   logic [3:0]  halves_q;
   logic [4:0]  clr_f;
   logic [3:0]  clr_n;
   logic        clr_seq_ok, out_range, pending;
   logic [7:0]  abs_err;
   logic [15:0] avg_sum;

   // write-one-to-clear strobes per flag register
   assign clr_f = (reg_wr && reg_addr == hedt_pkg::ADR_FAULT) ?
                  reg_wdata[4:0] : 5'h00;
   assign clr_n = (reg_wr && reg_addr == hedt_pkg::ADR_NOTE) ?
                  reg_wdata[3:0] : 4'h0;
   // pulse timeout blocks the summary clear until restart
   assign clr_seq_ok = clr_f[hedt_pkg::F_SEQ] &&
                       (!inf_q[hedt_pkg::I_PWM] || pwm_rst_seen_q);
   // frequency window check on the new half period
   assign out_range = hp_tick && !ctrl_q[hedt_pkg::C_BYP] &&
      (hp_period > hedt_pkg::PER_MAX ||
       hp_period < hedt_pkg::PER_MIN);

   // fault flags: set wins over clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_q <= 5'h00;
      end else begin
         fault_q[hedt_pkg::F_OC]  <= (fault_q[hedt_pkg::F_OC] &
            ~clr_f[hedt_pkg::F_OC]) | oc_evt;
         fault_q[hedt_pkg::F_HOT] <= (fault_q[hedt_pkg::F_HOT] &
            ~clr_f[hedt_pkg::F_HOT]) | hot_evt;
         fault_q[hedt_pkg::F_UV]  <= (fault_q[hedt_pkg::F_UV] &
            ~clr_f[hedt_pkg::F_UV]) | uv_evt;
         fault_q[hedt_pkg::F_ACT] <= (fault_q[hedt_pkg::F_ACT] &
            ~clr_f[hedt_pkg::F_ACT]) | act_imp_evt | act_bemf_evt |
            out_range;
         fault_q[hedt_pkg::F_SEQ] <= (fault_q[hedt_pkg::F_SEQ] &
            ~clr_seq_ok) | bad_id_evt | mem_bad_evt | pwm_tmo_evt;
      end
   end

   // input fault causes, cleared with the summary flag
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         inf_q          <= 3'h0;
         pwm_rst_seen_q <= 1'b0;
      end else begin
         inf_q <= (inf_q & {3{~clr_seq_ok}}) |
                  {pwm_tmo_evt, mem_bad_evt, bad_id_evt};
         if (pwm_tmo_evt)
            pwm_rst_seen_q <= 1'b0;
         else if (pwm_restart && inf_q[hedt_pkg::I_PWM])
            pwm_rst_seen_q <= 1'b1;
      end
   end

   // warning details and notifications
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         warn_q <= 3'h0;
         note_q <= 4'h0;
      end else begin
         warn_q <= (warn_q & ~((reg_wr && reg_addr == hedt_pkg::ADR_WARN)
            ? reg_wdata[2:0] : 3'h0)) |
            {fmt_evt, boost_evt, lim_evt};
         note_q[hedt_pkg::N_DONE] <= (note_q[hedt_pkg::N_DONE] &
            ~clr_n[hedt_pkg::N_DONE]) | done_evt;
         note_q[hedt_pkg::N_REP]  <= (note_q[hedt_pkg::N_REP] &
            ~clr_n[hedt_pkg::N_REP]) |
            (seq_begin_evt & ctrl_q[hedt_pkg::C_REPEAT]);
         note_q[hedt_pkg::N_WARN] <= |warn_q;
         note_q[hedt_pkg::N_SAT]  <= (note_q[hedt_pkg::N_SAT] &
            ~clr_n[hedt_pkg::N_SAT]) | sat_evt;
      end
   end

   // host-written configuration registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mska_q      <= 8'h00;
         mskb_q      <= 8'h00;
         kp_q        <= hedt_pkg::KP_RST;
         ki_q        <= hedt_pkg::KI_RST;
         ctrl_q      <= 8'h00;
         lock_q      <= hedt_pkg::LOCK_RST;
         floor_q     <= hedt_pkg::FLOOR_RST;
         brake_thr_q <= hedt_pkg::BRAKE_RST;
      end else begin
         if (reg_wr) begin
            unique case (reg_addr)
               hedt_pkg::ADR_MSKA:  mska_q        <= reg_wdata;
               hedt_pkg::ADR_MSKB:  mskb_q        <= reg_wdata;
               hedt_pkg::ADR_KP_H:  kp_q[15:8]    <= reg_wdata;
               hedt_pkg::ADR_KP_L:  kp_q[7:0]     <= reg_wdata;
               hedt_pkg::ADR_KI_H:  ki_q[15:8]    <= reg_wdata;
               hedt_pkg::ADR_KI_L:  ki_q[7:0]     <= reg_wdata;
               hedt_pkg::ADR_CTRL:  ctrl_q        <= reg_wdata;
               hedt_pkg::ADR_LOCK:  lock_q        <= reg_wdata;
               hedt_pkg::ADR_FLOOR: floor_q       <= reg_wdata;
               hedt_pkg::ADR_BRAKE: brake_thr_q   <= reg_wdata;
               default: ;
            endcase
         end
         // repeat request is consumed when the new pass begins
         if (seq_begin_evt)
            ctrl_q[hedt_pkg::C_REPEAT] <= 1'b0;
      end
   end

   // half-period measurement: latest value and four-deep history
   assign avg_sum = 16'(hist_q[0]) + 16'(hist_q[1]) +
                    16'(hist_q[2]) + 16'(hist_q[3]);
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pnow_q <= 14'h0000;
         pavg_q <= 14'h0000;
         for (int i = 0; i < 4; i++)
            hist_q[i] <= 14'h0000;
      end else begin
         if (hp_tick) begin
            pnow_q    <= hp_period;
            hist_q[0] <= hp_period;
            for (int i = 1; i < 4; i++)
               hist_q[i] <= hist_q[i-1];
         end
         pavg_q <= avg_sum[15:2];
      end
   end

   // pi frequency tracking
   assign track_on = playing && (bemf_lvl >= floor_q);
   assign abs_err  = trk_err[7] ? 8'(-trk_err) : trk_err;
   assign pterm = (ctrl_q[hedt_pkg::C_AUTO] && locked_q) ?
      24'($signed(trk_err) * $signed({1'b0, kp_q}) >>> 1) :
      24'($signed(trk_err) * $signed({1'b0, kp_q}));
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         integ_q   <= 24'h000000;
         locked_q  <= 1'b0;
         track_adj <= 16'h0000;
      end else begin
         if (!playing) begin
            locked_q <= 1'b0;
            integ_q  <= 24'h000000;
         end else if (hp_tick && track_on) begin
            integ_q <= integ_q +
               24'($signed(trk_err) * $signed({1'b0, ki_q}));
            if (abs_err <= lock_q)
               locked_q <= 1'b1;
         end
         track_adj <= 16'((pterm + integ_q) >> 8);
      end
   end

   // quick brake for sequences past three half periods
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         halves_q    <= 4'h0;
         brake_drive <= 1'b0;
      end else begin
         if (!playing)
            halves_q <= 4'h0;
         else if (hp_tick && halves_q != 4'hf)
            halves_q <= halves_q + 4'h1;
         if (brake_drive && (accel_zero || bemf_lvl <= brake_thr_q))
            brake_drive <= 1'b0;
         else if (stop_req && halves_q > hedt_pkg::BRAKE_MIN_HALVES)
            brake_drive <= 1'b1;
      end
   end

   // one-shot resistance and scale update
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         res_q   <= 10'h000;
         scale_q <= hedt_pkg::SCALE_RST;
      end else if (first_drive && !(ctrl_q[hedt_pkg::C_HOLD] &&
                   ctrl_q[hedt_pkg::C_CALOFF])) begin
         res_q   <= meas_res;
         scale_q <= meas_scale;
      end
   end

   // alert pin and idle hold
   assign pending = |({3'h0, fault_q} & ~mska_q) |
                    |({4'h0, note_q} & ~mskb_q);
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         event_alert_pin_o    <= 1'b0;
         event_alert_pin_oe_b <= 1'b1;
         hold_idle            <= 1'b0;
      end else begin
         event_alert_pin_o    <= 1'b0;
         event_alert_pin_oe_b <= ~pending;
         hold_idle            <= |fault_q;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            hedt_pkg::ADR_FAULT: reg_rdata <= {3'h0, fault_q};
            hedt_pkg::ADR_NOTE:  reg_rdata <= {4'h0, note_q};
            hedt_pkg::ADR_WARN:  reg_rdata <= {5'h00, warn_q};
            hedt_pkg::ADR_INF:   reg_rdata <= {5'h00, inf_q};
            hedt_pkg::ADR_MSKA:  reg_rdata <= mska_q;
            hedt_pkg::ADR_MSKB:  reg_rdata <= mskb_q;
            hedt_pkg::ADR_KP_H:  reg_rdata <= kp_q[15:8];
            hedt_pkg::ADR_KP_L:  reg_rdata <= kp_q[7:0];
            hedt_pkg::ADR_KI_H:  reg_rdata <= ki_q[15:8];
            hedt_pkg::ADR_KI_L:  reg_rdata <= ki_q[7:0];
            hedt_pkg::ADR_CTRL:  reg_rdata <= ctrl_q;
            hedt_pkg::ADR_LOCK:  reg_rdata <= lock_q;
            hedt_pkg::ADR_FLOOR: reg_rdata <= floor_q;
            hedt_pkg::ADR_BRAKE: reg_rdata <= brake_thr_q;
            hedt_pkg::ADR_PN_H:
               reg_rdata <= {1'b0, pnow_q[13:hedt_pkg::PER_LW]};
            hedt_pkg::ADR_PN_L:
               reg_rdata <= {1'b0, pnow_q[hedt_pkg::PER_LW-1:0]};
            hedt_pkg::ADR_PA_H:
               reg_rdata <= {1'b0, pavg_q[13:hedt_pkg::PER_LW]};
            hedt_pkg::ADR_PA_L:
               reg_rdata <= {1'b0, pavg_q[hedt_pkg::PER_LW-1:0]};
            hedt_pkg::ADR_SC_H:  reg_rdata <= scale_q[15:8];
            hedt_pkg::ADR_SC_L:  reg_rdata <= scale_q[7:0];
            hedt_pkg::ADR_RS_H:  reg_rdata <= res_q[9:hedt_pkg::RES_LW];
            hedt_pkg::ADR_RS_L:
               reg_rdata <= {6'h00, res_q[hedt_pkg::RES_LW-1:0]};
            hedt_pkg::ADR_STAT:
               reg_rdata <= {4'h0, track_on, locked_q, brake_drive,
                             hold_idle};
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_pwm_timeout;
      inf_q[hedt_pkg::I_PWM] && !pwm_rst_seen_q;
   endsequence
   sequence s_blocked_clear;
      reg_wr && reg_addr == hedt_pkg::ADR_FAULT &&
      reg_wdata[hedt_pkg::F_SEQ] && !oc_evt;
   endsequence

   AST_FAULT_IDLE: assert property (
      oc_evt |=> ##1 hold_idle)
      else $error("fault did not hold idle");
   AST_ALERT_LOW: assert property (
      uv_evt && !mska_q[hedt_pkg::F_UV] |=> ##1 !event_alert_pin_oe_b)
      else $error("alert not pulled low");
   AST_OC_SET: assert property (
      oc_evt |=> fault_q[hedt_pkg::F_OC])
      else $error("overcurrent flag not set");
   AST_SEQ_CAUSE: assert property (
      bad_id_evt |=> fault_q[hedt_pkg::F_SEQ] && inf_q[hedt_pkg::I_ID])
      else $error("sequence cause not recorded");
   AST_PWM_HOLD: assert property (
      s_pwm_timeout ##0 s_blocked_clear
      |=> fault_q[hedt_pkg::F_SEQ])
      else $error("timeout cleared before restart");
   AST_RANGE: assert property (
      out_range |=> fault_q[hedt_pkg::F_ACT])
      else $error("frequency window fault missed");
   AST_SUSPEND: assert property (
      playing && bemf_lvl < floor_q |=> $stable(integ_q))
      else $error("tracking ran below floor");
   AST_PERIOD: assert property (
      hp_tick |=> pnow_q == $past(hp_period))
      else $error("period not captured");
   AST_BRAKE_END: assert property (
      brake_drive && accel_zero |=> !brake_drive)
      else $error("brake did not stop");
   AST_RELEASE: assert property (
      !pending [*2] |-> event_alert_pin_oe_b)
      else $error("alert not released");
endmodule
`default_nettype wire

// >>> common/hedt_pkg.sv
// constants for the haptic event, diagnostic and tracking block
// assumes an 8-bit register port with up to 32 registers
package hedt_pkg;
   // register addresses
   localparam logic [4:0] ADR_FAULT = 5'h00; // fault_summary_byte
   localparam logic [4:0] ADR_NOTE  = 5'h01; // notification flags
   localparam logic [4:0] ADR_WARN  = 5'h02; // warning_detail
   localparam logic [4:0] ADR_INF   = 5'h03; // input_fault_detail
   localparam logic [4:0] ADR_MSKA  = 5'h04; // event_mask_a
   localparam logic [4:0] ADR_MSKB  = 5'h05; // event_mask_b
   localparam logic [4:0] ADR_KP_H  = 5'h06;
   localparam logic [4:0] ADR_KP_L  = 5'h07;
   localparam logic [4:0] ADR_KI_H  = 5'h08;
   localparam logic [4:0] ADR_KI_L  = 5'h09;
   localparam logic [4:0] ADR_CTRL  = 5'h0a;
   localparam logic [4:0] ADR_LOCK  = 5'h0b;
   localparam logic [4:0] ADR_FLOOR = 5'h0c;
   localparam logic [4:0] ADR_BRAKE = 5'h0d;
   localparam logic [4:0] ADR_PN_H  = 5'h0e;
   localparam logic [4:0] ADR_PN_L  = 5'h0f;
   localparam logic [4:0] ADR_PA_H  = 5'h10;
   localparam logic [4:0] ADR_PA_L  = 5'h11;
   localparam logic [4:0] ADR_SC_H  = 5'h12;
   localparam logic [4:0] ADR_SC_L  = 5'h13;
   localparam logic [4:0] ADR_RS_H  = 5'h14;
   localparam logic [4:0] ADR_RS_L  = 5'h15;
   localparam logic [4:0] ADR_STAT  = 5'h16;
   // fault bits
   localparam int F_OC = 0, F_ACT = 1, F_SEQ = 2, F_HOT = 3, F_UV = 4;
   // notification bits
   localparam int N_DONE = 0, N_REP = 1, N_WARN = 2, N_SAT = 3;
   // warning and input fault detail bits
   localparam int W_LIM = 0, W_BOOST = 1, W_FMT = 2;
   localparam int I_ID = 0, I_MEM = 1, I_PWM = 2;
   // control bits
   localparam int C_AUTO = 0, C_BYP = 1, C_HOLD = 2, C_CALOFF = 3;
   localparam int C_REPEAT = 4;
   // reset values
   localparam logic [15:0] KP_RST    = 16'h0100;
   localparam logic [15:0] KI_RST    = 16'h0040;
   localparam logic [7:0]  LOCK_RST  = 8'h08;
   localparam logic [7:0]  FLOOR_RST = 8'h10;
   localparam logic [7:0]  BRAKE_RST = 8'h20;
   localparam logic [15:0] SCALE_RST = 16'h0400;
   // period encoding: high * 128 + low, unit 1333.32 ns
   localparam int PER_LW = 7;
   localparam int RES_LW = 2; // resistance: high * 4 + low
   localparam longint UNIT_PS = 64'd1333320;
   localparam longint FMIN_HZ = 64'd50;
   localparam longint FMAX_HZ = 64'd300;
   localparam logic [13:0] PER_MAX =
      14'(64'd1000000000000 / (FMIN_HZ * UNIT_PS));
   localparam logic [13:0] PER_MIN =
      14'((64'd1000000000000 + FMAX_HZ * UNIT_PS - 1) / (FMAX_HZ * UNIT_PS));
   localparam logic [3:0] BRAKE_MIN_HALVES = 4'h3;
endpackage

// >>> testbench/hedt_host_model.sv
// host side of the alert line and the pulse-width input restart
// assumes the core drives the pin low only while oe_b is low
`timescale 1ns/1ps
`default_nettype none
module hedt_host_model (
   input  wire logic ref_clk,
   input  wire logic pin_o,
   input  wire logic pin_oe_b,
   output logic      alert_line,
   output logic      pwm_restart
);
   // board pull-up wins whenever the core lets go
   assign alert_line = pin_oe_b ? 1'b1 : pin_o;

   initial pwm_restart = 1'b0;

   // restart the pulse input before clearing its timeout
   task automatic restart_pwm();
      @(posedge ref_clk) pwm_restart <= 1'b1;
      @(posedge ref_clk) pwm_restart <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/haptic_event_diag_tracking_tb_top.sv
// self-checking bench for the event, diagnostic and tracking core
// assumes a 200 MHz clock and the one-cycle register port
`timescale 1ns/1ps
`default_nettype none
module haptic_event_diag_tracking_tb_top;
   logic        ref_clk, rst_b, reg_wr, reg_rd, hp_tick, playing;
   logic        stop_req, accel_zero, first_drive;
   logic [4:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, bemf_lvl, trk_err;
   logic [13:0] ev, hp_period;
   logic [9:0]  meas_res;
   logic [15:0] meas_scale, track_adj;
   logic        pin_o, pin_oe_b, hold_idle, brake_drive, line, restart;
   int          error_cnt, num_checks, cyc;

   // clock at 5 ns
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   hedt_core i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .oc_evt(ev[0]), .hot_evt(ev[1]),
      .uv_evt(ev[2]), .act_imp_evt(ev[3]), .act_bemf_evt(ev[4]),
      .bad_id_evt(ev[5]), .mem_bad_evt(ev[6]), .pwm_tmo_evt(ev[7]),
      .pwm_restart(restart), .done_evt(ev[8]), .seq_begin_evt(ev[9]),
      .sat_evt(ev[10]), .lim_evt(ev[11]), .boost_evt(ev[12]),
      .fmt_evt(ev[13]), .hp_tick(hp_tick), .hp_period(hp_period),
      .bemf_lvl(bemf_lvl), .trk_err(trk_err), .playing(playing),
      .stop_req(stop_req), .accel_zero(accel_zero),
      .first_drive(first_drive), .meas_res(meas_res),
      .meas_scale(meas_scale), .event_alert_pin_o(pin_o),
      .event_alert_pin_oe_b(pin_oe_b), .hold_idle(hold_idle),
      .brake_drive(brake_drive), .track_adj(track_adj));

   hedt_host_model i_host (.ref_clk(ref_clk), .pin_o(pin_o),
      .pin_oe_b(pin_oe_b), .alert_line(line), .pwm_restart(restart));

   // verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk) begin
         reg_wr    <= 1'b1;
         reg_addr  <= a;
         reg_wdata <= d;
      end
      @(posedge ref_clk) reg_wr <= 1'b0;
   endtask

   // read and compare in the data cycle
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge ref_clk) begin
         reg_rd   <= 1'b1;
         reg_addr <= a;
      end
      @(posedge ref_clk) reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask

   task automatic pulse(input int i);
      @(posedge ref_clk) ev[i] <= 1'b1;
      @(posedge ref_clk) ev[i] <= 1'b0;
      tick(2);
   endtask

   task automatic half(input logic [13:0] p);
      @(posedge ref_clk) begin
         hp_tick   <= 1'b1;
         hp_period <= p;
      end
      @(posedge ref_clk) hp_tick <= 1'b0;
   endtask

   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc >= 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   logic [4:0]  rst_a [10] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c,
                               5'h0d, 5'h12, 5'h13, 5'h1f};
   logic [7:0]  rst_v [10] = '{8'h01, 8'h00, 8'h00, 8'h40, 8'h08, 8'h10,
                               8'h20, 8'h04, 8'h00, 8'h00};
   int          f_ev  [5]  = '{0, 1, 2, 3, 4};
   logic [7:0]  f_bit [5]  = '{8'h01, 8'h08, 8'h10, 8'h02, 8'h02};

   initial begin
      {reg_wr, reg_rd, hp_tick, playing, stop_req, accel_zero} = '0;
      {first_drive, reg_addr, reg_wdata, ev, hp_period, trk_err} = '0;
      {meas_res, meas_scale} = '0;
      bemf_lvl = 8'h80;
      rst_b = 1'b0;
      tick(5);
      @(posedge ref_clk) rst_b <= 1'b1;
      // reset values and an unmapped read
      for (int i = 0; i < 10; i++) rd(rst_a[i], rst_v[i]);
      // each fault but the sequence fault forces idle, drives the pin, clears on write of one
      for (int i = 0; i < 5; i++) begin
         pulse(f_ev[i]);
         rd(hedt_pkg::ADR_FAULT, f_bit[i]);
         chk(hold_idle, 1'b1);
         chk(line, 1'b0);
         wr(hedt_pkg::ADR_FAULT, f_bit[i]);
         tick(2);
         chk({hold_idle, line}, 2'b01);
      end
      // input data faults record their cause
      pulse(5);
      pulse(6);
      rd(hedt_pkg::ADR_FAULT, 8'h04);
      rd(hedt_pkg::ADR_INF, 8'h03);
      wr(hedt_pkg::ADR_FAULT, 8'h04);
      rd(hedt_pkg::ADR_INF, 8'h00);
      // timeout clear refused until the input is restarted
      pulse(7);
      rd(hedt_pkg::ADR_INF, 8'h04);
      wr(hedt_pkg::ADR_FAULT, 8'h04);
      rd(hedt_pkg::ADR_FAULT, 8'h04);
      i_host.restart_pwm();
      wr(hedt_pkg::ADR_FAULT, 8'h04);
      rd(hedt_pkg::ADR_FAULT, 8'h00);
      // notifications leave the state alone
      wr(hedt_pkg::ADR_CTRL, 8'h10);
      pulse(8);
      pulse(9);
      pulse(10);
      rd(hedt_pkg::ADR_NOTE, 8'h0b);
      chk({hold_idle, line}, 2'b00);
      wr(hedt_pkg::ADR_NOTE, 8'h0b);
      tick(2);
      chk(line, 1'b1);
      // warnings and the held summary flag
      pulse(11);
      pulse(12);
      pulse(13);
      rd(hedt_pkg::ADR_WARN, 8'h07);
      rd(hedt_pkg::ADR_NOTE, 8'h04);
      chk(hold_idle, 1'b0);
      wr(hedt_pkg::ADR_WARN, 8'h07);
      tick(1);
      rd(hedt_pkg::ADR_NOTE, 8'h00);
      // masked fault latches but keeps the pin released
      wr(hedt_pkg::ADR_MSKA, 8'h01);
      pulse(0);
      rd(hedt_pkg::ADR_FAULT, 8'h01);
      chk(line, 1'b1);
      wr(hedt_pkg::ADR_MSKA, 8'h00);
      tick(2);
      chk(line, 1'b0);
      wr(hedt_pkg::ADR_FAULT, 8'h01);
      // masked notification latches without pulling the pin
      wr(hedt_pkg::ADR_MSKB, 8'h01);
      pulse(8);
      chk(line, 1'b1);
      rd(hedt_pkg::ADR_NOTE, 8'h01);
      wr(hedt_pkg::ADR_NOTE, 8'h01);
      wr(hedt_pkg::ADR_MSKB, 8'h00);
      // period now and average of four halves
      half(14'd3000);
      half(14'd4000);
      half(14'd5000);
      half(14'd6000);
      rd(hedt_pkg::ADR_PN_H, 8'h2e);
      rd(hedt_pkg::ADR_PN_L, 8'h70);
      rd(hedt_pkg::ADR_PA_H, 8'h23);
      rd(hedt_pkg::ADR_PA_L, 8'h14);
      // range fault and its bypass
      half(14'd2000);
      rd(hedt_pkg::ADR_FAULT, 8'h02);
      wr(hedt_pkg::ADR_FAULT, 8'h02);
      wr(hedt_pkg::ADR_CTRL, 8'h02);
      half(14'd2000);
      rd(hedt_pkg::ADR_FAULT, 8'h00);
      wr(hedt_pkg::ADR_CTRL, 8'h00);
      // brake only after more than three halves
      @(posedge ref_clk) playing <= 1'b1;
      half(14'd4000);
      half(14'd4000);
      @(posedge ref_clk) stop_req <= 1'b1;
      @(posedge ref_clk) stop_req <= 1'b0;
      tick(2);
      chk(brake_drive, 1'b0);
      half(14'd4000);
      half(14'd4000);
      @(posedge ref_clk) stop_req <= 1'b1;
      @(posedge ref_clk) stop_req <= 1'b0;
      tick(1);
      chk(brake_drive, 1'b1);
      rd(hedt_pkg::ADR_STAT, 8'h0e);
      @(posedge ref_clk) accel_zero <= 1'b1;
      @(posedge ref_clk) accel_zero <= 1'b0;
      tick(2);
      chk(brake_drive, 1'b0);
      @(posedge ref_clk) stop_req <= 1'b1;
      @(posedge ref_clk) stop_req <= 1'b0;
      tick(1);
      chk(brake_drive, 1'b1);
      @(posedge ref_clk) bemf_lvl <= 8'h10;
      tick(3);
      chk(brake_drive, 1'b0);
      // one-shot resistance measure, then held
      @(posedge ref_clk) begin
         first_drive <= 1'b1;
         meas_res    <= 10'h2a5;
         meas_scale  <= 16'h1234;
      end
      @(posedge ref_clk) first_drive <= 1'b0;
      rd(hedt_pkg::ADR_RS_H, 8'ha9);
      rd(hedt_pkg::ADR_RS_L, 8'h01);
      rd(hedt_pkg::ADR_SC_H, 8'h12);
      wr(hedt_pkg::ADR_CTRL, 8'h0c);
      @(posedge ref_clk) begin
         first_drive <= 1'b1;
         meas_res    <= 10'h011;
         meas_scale  <= 16'h0777;
      end
      @(posedge ref_clk) first_drive <= 1'b0;
      rd(hedt_pkg::ADR_RS_H, 8'ha9);
      rd(hedt_pkg::ADR_SC_L, 8'h34);
      // pi tracking: gain write, suspension below floor, autoscale
      wr(hedt_pkg::ADR_KP_H, 8'h02);
      @(posedge ref_clk) trk_err <= 8'h04;
      half(14'd4000);
      tick(2);
      chk(track_adj, 16'h0009);
      @(posedge ref_clk) bemf_lvl <= 8'h08;
      half(14'd4000);
      tick(2);
      chk(track_adj, 16'h0009);
      wr(hedt_pkg::ADR_CTRL, 8'h0d);
      tick(2);
      chk(track_adj, 16'h0005);
      @(posedge ref_clk) playing <= 1'b0;
      @(posedge ref_clk) playing <= 1'b1;
      tick(2);
      chk(track_adj, 16'h0008);
      give_verdict();
   end
endmodule
`default_nettype wire
